// >>> dv/flash_settings_write_decoder_tb.sv
// testbench of the flash settings write decoder
`timescale 1ns/10ps
`include "fswd_regs.svh"
module flash_settings_write_decoder_tb import fswd_pkg::*;;
	logic clk_sys, srst, intMonitor, irq, read, write, waitrequest;
	fswd_byte_type rptIn;
	fswd_chip_type chipCfg;
	fswd_usb_type usbCfg;
	fswd_pin_type pin0Cfg, pin1Cfg;
	logic [1:0] pinOut, pinOeN;
	logic [4:0] address;
	logic [31:0] writedata, readdata, rd, pinExp;
	logic [3:0] byteenable;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;

	fswd_decoder #(.REPORT_LEN(64)) u_dut (.clk_sys(clk_sys), .srst(srst), .rptIn(rptIn),
		.intMonitor(intMonitor), .chipCfg(chipCfg), .usbCfg(usbCfg), .pin0Cfg(pin0Cfg), .pin1Cfg(pin1Cfg),
		.pinOut(pinOut), .pinOeN(pinOeN), .irq(irq), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
	fswd_host_model u_host (.clk_sys(clk_sys), .rptIn(rptIn));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// helpers
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			print_verdict;
		end
	end
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task avRead(input logic [4:0] a, input logic [31:0] exp, input string name);
		address <= a;
		read <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		@(posedge clk_sys);
		chk(name, exp, rd);
	endtask
	task avWrite(input logic [4:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task fill(input logic [7:0] cmd, input logic [7:0] sub);
		for (int i = 2; i < 64; i++)
			u_host.msg[i] = 8'hee;
		u_host.msg[0] = cmd;
		u_host.msg[1] = sub;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		srst = 1'b1;
		intMonitor = 1'b0;
		address = 5'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hf;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		avRead(`FSWD_REG_CHIP, 32'h0, "chip reset");
		avRead(`FSWD_REG_PIN, 32'h0808, "pin reset");
		avRead(5'h1e, 32'h0, "unmapped");
		chk("drive reset", 32'h3, 32'(pinOeN));
		// chip report: edge enables, reference, ids, power, password
		fill(8'hb1, 8'h00);
		u_host.msg[5] = 8'hb5;
		{u_host.msg[7], u_host.msg[6], u_host.msg[9], u_host.msg[8]} = 32'h12345678;
		{u_host.msg[10], u_host.msg[11]} = 16'h80fa;
		for (int i = 0; i < 8; i++)
			u_host.msg[12 + i] = 8'ha0 + 8'(i);
		u_host.send(64);
		avWrite(`FSWD_REG_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irq set", 32'h1, 32'(irq));
		avWrite(`FSWD_REG_CHIP, 32'hffffffff);
		avRead(`FSWD_REG_CHIP, 32'h0d, "chip");
		avRead(`FSWD_REG_USB_ID, 32'h56781234, "usb id");
		avRead(`FSWD_REG_USB_POWER, 32'h1f480, "usb power");
		chk("chip port", 32'h0d, 32'(chipCfg));
		chk("usb id port", 32'h56781234, {usbCfg.productId, usbCfg.vendorId});
		chk("current port", 32'h1f4, 32'(usbCfg.currentMa));
		chk("attr port", 32'h80, 32'(usbCfg.powerAttr));
		for (int j = 0; j < 8; j += 7) begin
			avWrite(`FSWD_REG_PW_INDEX, 32'(j));
			avRead(`FSWD_REG_PW_DATA, 32'ha0 + 32'(j), "password");
		end
		avRead(`FSWD_REG_STATUS, 32'h1, "status chip");
		avWrite(`FSWD_REG_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irq clear", 32'h0, 32'(irq));
		// rising edge enabled, falling edge not
		intMonitor <= 1'b1;
		repeat (6) @(posedge clk_sys);
		avRead(`FSWD_REG_STATUS, 32'h8, "rise flag");
		avWrite(`FSWD_REG_STATUS, 32'h8);
		intMonitor <= 1'b0;
		repeat (6) @(posedge clk_sys);
		avRead(`FSWD_REG_STATUS, 32'h0, "fall flag");
		// pin reports over every function code, shortest legal length last
		for (int i = 0; i < 5; i++) begin
			fill(8'hb1, 8'h01);
			u_host.msg[2] = {3'b111, i[0], 1'b0, 3'(i % 3)};
			u_host.msg[3] = {3'b101, 1'b1, i[1], 3'(i)};
			u_host.send(i == 4 ? 4 : 64);
			pinExp = {19'h0, u_host.msg[3][4:0], 3'h0, u_host.msg[2][4:0]};
			avRead(`FSWD_REG_PIN, pinExp, "pin");
			chk("pin port", pinExp, {19'h0, pin1Cfg, 3'h0, pin0Cfg});
			chk("pin level", {30'h0, 1'b1, i[0]}, 32'(pinOut));
			chk("pin drive", {30'h0, i != 0, (i % 3) != 0}, 32'(pinOeN));
		end
		avRead(`FSWD_REG_STATUS, 32'h2, "status pin");
		avWrite(`FSWD_REG_STATUS, 32'hf);
		// other command code leaves all settings alone
		fill(8'ha1, 8'h01);
		u_host.msg[2] = 8'h00;
		u_host.send(64);
		avRead(`FSWD_REG_PIN, pinExp, "pin kept");
		avRead(`FSWD_REG_STATUS, 32'h0, "status none");
		// chip report one byte short of the password end
		fill(8'hb1, 8'h00);
		u_host.send(19);
		avRead(`FSWD_REG_CHIP, 32'h0d, "chip kept");
		avRead(`FSWD_REG_STATUS, 32'h4, "status short");
		avWrite(`FSWD_REG_STATUS, 32'hf);
		// shortest complete chip report: falling edge only, reference off, supply source
		fill(8'hb1, 8'h00);
		u_host.msg[5] = 8'h40;
		u_host.send(20);
		avRead(`FSWD_REG_CHIP, 32'h10, "chip fall");
		avRead(`FSWD_REG_USB_POWER, 32'h1dcee, "usb power fill");
		avRead(`FSWD_REG_PW_DATA, 32'hee, "password new");
		intMonitor <= 1'b1;
		repeat (6) @(posedge clk_sys);
		avRead(`FSWD_REG_STATUS, 32'h1, "rise off");
		intMonitor <= 1'b0;
		repeat (6) @(posedge clk_sys);
		avRead(`FSWD_REG_STATUS, 32'h9, "fall on");
		// unknown sub-code is flagged and stores nothing
		avWrite(`FSWD_REG_STATUS, 32'hf);
		fill(8'hb1, 8'h02);
		u_host.send(64);
		avRead(`FSWD_REG_STATUS, 32'h4, "status sub");
		avRead(`FSWD_REG_PIN, pinExp, "pin sub kept");
		// byte lane zero gates mask writes
		byteenable <= 4'he;
		avWrite(`FSWD_REG_MASK, 32'hf);
		byteenable <= 4'hf;
		avRead(`FSWD_REG_MASK, 32'h1, "mask lane");
		print_verdict;
	end
endmodule

// >>> dv/fswd_host_model.sv
// host side model: sends configuration reports byte by byte
`timescale 1ns/10ps
module fswd_host_model
	import fswd_pkg::*;
(
	input wire logic clk_sys,
	output fswd_byte_type rptIn
);
	logic [7:0] msg [64];
	initial rptIn = '0;
	// msg[0] holds the command code, msg[1] the sub-code
	task automatic send(input int len);
		for (int i = 0; i < len; i++) begin
			rptIn <= '{valid: 1'b1, last: (i == len - 1), data: msg[i]};
			@(posedge clk_sys);
		end
		// idle line shows the inverse so a stale byte is never taken for data
		rptIn <= '{valid: 1'b0, last: 1'b0, data: ~msg[len - 1]};
	endtask
endmodule

// >>> dv/fswd_properties.sv
// checker of the flash settings write decoder outputs
`timescale 1ns/10ps
`include "fswd_regs.svh"
module fswd_checker
	import fswd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire fswd_byte_type rptIn,
	input wire fswd_chip_type chipCfg,
	input wire fswd_usb_type usbCfg,
	input wire fswd_pin_type pin0Cfg,
	input wire fswd_pin_type pin1Cfg,
	input wire logic [1:0] pinOut,
	input wire logic [1:0] pinOeN,
	input wire logic read,
	input wire logic waitrequest
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// ==========================================================
	// helper: was byte zero of the report in flight the flash-write code
	logic atStart_r;
	logic isFlash_r;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			atStart_r <= 1'b1;
			isFlash_r <= 1'b0;
		end else if (rptIn.valid) begin
			atStart_r <= rptIn.last;
			if (atStart_r)
				isFlash_r <= (rptIn.data == `FSWD_CMD_FLASH_WRITE);
		end
	end
	// ==========================================================
	// properties
	chk_flash_only: assert property (($changed(chipCfg) || $changed(pin0Cfg)) |-> $past(isFlash_r))
		else $error("config changed by a non flash report");
	chk_pin_commit: assert property ($changed(pin1Cfg) |-> $past(rptIn.valid && rptIn.last))
		else $error("pin config changed off a last byte");
	chk_chip_commit: assert property ($changed(chipCfg) |-> $past(rptIn.valid && rptIn.last))
		else $error("chip config changed off a last byte");
	chk_usb_commit: assert property ($changed(usbCfg) |-> $past(rptIn.valid && rptIn.last))
		else $error("usb config changed off a last byte");
	chk_current_even: assert property (usbCfg.currentMa[0] == 1'b0)
		else $error("current not twice a byte");
	chk_level_out: assert property (pinOut == {$past(pin1Cfg.level), $past(pin0Cfg.level)})
		else $error("pin level does not follow config");
	chk_drive_zero: assert property (pinOeN[0] == !($past(pin0Cfg.func) == 3'h0 && !$past(pin0Cfg.dirInput)))
		else $error("pin zero drive enable wrong");
	chk_drive_one: assert property (pinOeN[1] == !($past(pin1Cfg.func) == 3'h0 && !$past(pin1Cfg.dirInput)))
		else $error("pin one drive enable wrong");
	chk_read_wait: assert property ($rose(read) |-> waitrequest ##1 waitrequest ##1 !waitrequest)
		else $error("read wait states wrong");
endmodule

bind fswd_decoder fswd_checker u_chk (.clk_sys(clk_sys), .srst(srst), .rptIn(rptIn), .chipCfg(chipCfg),
	.usbCfg(usbCfg), .pin0Cfg(pin0Cfg), .pin1Cfg(pin1Cfg), .pinOut(pinOut), .pinOeN(pinOeN),
	.read(read), .waitrequest(waitrequest));

// >>> hw/fswd_decoder.sv
// flash settings write decoder: report parser, settings store, status, Avalon-MM slave
//
// Behaviour
// - a report whose byte zero is the flash-write code is a flash settings write
// - sub-code one at byte one means the following bytes are pin settings
// - chip byte five bit six enables the flag on a falling monitored edge
// - chip byte five bit five enables the flag on a rising monitored edge
// - byte five bits four..three pick internal converter reference level, zero means off
// - byte five bit two: one internal reference, zero supply voltage
// - vendor identifier is byte six low, byte seven high
// - product identifier is byte eight low, byte nine high
// - byte ten is kept and presented as the power attributes
// - requested bus current reported is twice the stored byte eleven
// - bytes twelve to nineteen are the password guarding later flash changes
// - pin byte bit four is the power-up output level of a general output
// - pin byte bit three: one input, zero output, only for general operation
// - pin zero function: 000 general, 001 receive led, 010 suspend indicator
// - pin byte three holds pin one settings laid out as pin zero
// - pin one function: general, clock, converter, transmit led, interrupt detection
`timescale 1ns/10ps
`include "fswd_regs.svh"
module fswd_decoder
	import fswd_pkg::*;
#(
	parameter int REPORT_LEN = 64
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire fswd_byte_type rptIn,
	input wire logic intMonitor,
	output fswd_chip_type chipCfg,
	output fswd_usb_type usbCfg,
	output fswd_pin_type pin0Cfg,
	output fswd_pin_type pin1Cfg,
	output logic [1:0] pinOut,
	output logic [1:0] pinOeN,
	output logic irq,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest
);

	if (REPORT_LEN < 20 || REPORT_LEN > 64) begin : gLenCheck
		$error("fswd_decoder: REPORT_LEN must lie in 20..64");
	end

	// the password span has to fill exactly one bank of the store
	if (`FSWD_IDX_PW_LAST - `FSWD_IDX_PW_FIRST != 6'h07) begin : gPwCheck
		$error("fswd_decoder: password span must be eight bytes");
	end

	// ======================================================================
	// state
	typedef struct packed {
		// parser position
		fswd_parse_type parse;
		logic [5:0] idx;
		logic cmdHit;
		// shadow copies: only a complete report commits them
		fswd_chip_type chipSh;
		logic [15:0] vidSh;
		logic [15:0] pidSh;
		logic [7:0] attrSh;
		logic [7:0] curSh;
		fswd_pin_type pin0Sh;
		fswd_pin_type pin1Sh;
		// committed settings
		fswd_chip_type chip;
		fswd_usb_type usb;
		fswd_pin_type pin0;
		fswd_pin_type pin1;
		logic pwBank;
		// power-up pin drive
		logic [1:0] pinOut;
		logic [1:0] pinOeN;
		// status and bus side
		logic [3:0] status;
		logic [3:0] mask;
		logic irq;
		logic [2:0] pwIndex;
		logic [1:0] rdPhase;
		logic [31:0] rdata;
		// monitored pin: two-flop synchroniser, then edge history
		logic syncA;
		logic syncB;
		logic monPrev;
	} fswd_state_type;

	fswd_state_type st_r;
	fswd_state_type st_nxt;

	logic pwWrEn;
	logic [3:0] pwWrAddr;
	logic [3:0] pwRdAddr;
	logic [7:0] pwRdData;
	logic [5:0] pwOff;
	logic [1:0] drive;
	logic [1:0] levelBits;
	logic [31:0] rdMux;

	// ======================================================================
	// password memory
	// two banks: a report cut short never disturbs the committed password
	// only the password bytes of a chip report reach the store
	assign pwOff = 6'(st_r.idx - `FSWD_IDX_PW_FIRST);
	assign pwWrEn = rptIn.valid && st_r.parse == PS_CHIP && st_r.idx >= `FSWD_IDX_PW_FIRST
		&& st_r.idx <= `FSWD_IDX_PW_LAST;
	// writes go to the idle bank, reads come from the committed one
	assign pwWrAddr = {~st_r.pwBank, pwOff[2:0]};
	assign pwRdAddr = {st_r.pwBank, st_r.pwIndex};

	fswd_pw_mem #(
		.WIDTH(8),
		.DEPTH(16)
	) uPwMem (
		.clk_sys(clk_sys),
		.wrEn(pwWrEn),
		.wrAddr(pwWrAddr),
		.wrData(rptIn.data),
		.rdAddr(pwRdAddr),
		.rdData(pwRdData)
	);

	// ======================================================================
	// per-pin power-up drive
	fswd_pin_type pinCfgs [2];
	assign pinCfgs[0] = st_r.pin0;
	assign pinCfgs[1] = st_r.pin1;

	for (genvar p = 0; p < 2; p++) begin : gPin
		// direction only counts in general-purpose operation
		assign drive[p] = pinCfgs[p].func == `FSWD_PIN_FN_GENERAL && !pinCfgs[p].dirInput;
		// the level is presented even while undriven; the enable alone decides
		assign levelBits[p] = pinCfgs[p].level;
	end

	// ======================================================================
	// register read multiplexer
	always_comb begin
		case (address)
			`FSWD_REG_STATUS: rdMux = {28'h0, st_r.status};
			`FSWD_REG_MASK: rdMux = {28'h0, st_r.mask};
			`FSWD_REG_CHIP: rdMux = {27'h0, st_r.chip};
			`FSWD_REG_USB_ID: rdMux = {st_r.usb.productId, st_r.usb.vendorId};
			`FSWD_REG_USB_POWER: rdMux = {15'h0, st_r.usb.currentMa, st_r.usb.powerAttr};
			`FSWD_REG_PIN: rdMux = {19'h0, st_r.pin1, 3'h0, st_r.pin0};
			`FSWD_REG_PW_INDEX: rdMux = {29'h0, st_r.pwIndex};
			`FSWD_REG_PW_DATA: rdMux = {24'h0, pwRdData};
			default: rdMux = 32'h0;
		endcase
	end

	// ======================================================================
	// next state
	always_comb begin
		logic [3:0] evSet;
		logic [3:0] evClr;
		logic commitChip;
		logic commitPin;
		logic rise;
		logic fall;
		evSet = 4'h0;
		evClr = 4'h0;
		commitChip = 1'b0;
		commitPin = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		st_nxt = st_r;

		// monitored input: two flops, then edge detect
		st_nxt.syncA = intMonitor;
		st_nxt.syncB = st_r.syncA;
		st_nxt.monPrev = st_r.syncB;
		// history resets low: a pin idling high shows one rise, harmless as the enables reset off
		rise = st_r.syncB && !st_r.monPrev;
		fall = !st_r.syncB && st_r.monPrev;
		if ((rise && st_r.chip.posEdgeEn) || (fall && st_r.chip.negEdgeEn)) begin
			evSet[`FSWD_ST_EDGE] = 1'b1;
		end

		// ------------------------------------------------------------------
		// report parser
		if (rptIn.valid) begin
			// index saturates so an overlong report never wraps onto byte zero
			if (st_r.idx != 6'(REPORT_LEN - 1)) begin
				st_nxt.idx = 6'(st_r.idx + 6'h01);
			end
			case (st_r.parse)
				// byte zero picks the command, byte one the kind of settings
				PS_HEAD: begin
					if (st_r.idx == `FSWD_IDX_CMD) begin
						st_nxt.cmdHit = rptIn.data == `FSWD_CMD_FLASH_WRITE;
						if (rptIn.data != `FSWD_CMD_FLASH_WRITE) begin
							st_nxt.parse = PS_SKIP;
						end
					end else if (rptIn.data == `FSWD_SUB_CHIP) begin
						st_nxt.parse = PS_CHIP;
					end else if (rptIn.data == `FSWD_SUB_PIN) begin
						st_nxt.parse = PS_PIN;
					end else begin
						st_nxt.parse = PS_SKIP;
					end
				end
				PS_CHIP: begin
					// bytes two to four and twenty onward are not this block's
					case (st_r.idx)
						`FSWD_IDX_EDGE: begin
							st_nxt.chipSh.negEdgeEn = rptIn.data[`FSWD_NEG_BIT];
							st_nxt.chipSh.posEdgeEn = rptIn.data[`FSWD_POS_BIT];
							st_nxt.chipSh.adcRefLevel = rptIn.data[`FSWD_REF_HI:`FSWD_REF_LO];
							st_nxt.chipSh.adcRefInternal = rptIn.data[`FSWD_SRC_BIT];
						end
						`FSWD_IDX_VID_LO: st_nxt.vidSh[7:0] = rptIn.data;
						`FSWD_IDX_VID_HI: st_nxt.vidSh[15:8] = rptIn.data;
						`FSWD_IDX_PID_LO: st_nxt.pidSh[7:0] = rptIn.data;
						`FSWD_IDX_PID_HI: st_nxt.pidSh[15:8] = rptIn.data;
						`FSWD_IDX_ATTR: st_nxt.attrSh = rptIn.data;
						`FSWD_IDX_CURRENT: st_nxt.curSh = rptIn.data;
						default: begin
						end
					endcase
				end
				PS_PIN: begin
					// bits seven to five are dropped
					if (st_r.idx == `FSWD_IDX_PIN0) begin
						st_nxt.pin0Sh.level = rptIn.data[`FSWD_PIN_LVL_BIT];
						st_nxt.pin0Sh.dirInput = rptIn.data[`FSWD_PIN_DIR_BIT];
						st_nxt.pin0Sh.func = rptIn.data[`FSWD_PIN_FN_HI:0];
					end else if (st_r.idx == `FSWD_IDX_PIN1) begin
						st_nxt.pin1Sh.level = rptIn.data[`FSWD_PIN_LVL_BIT];
						st_nxt.pin1Sh.dirInput = rptIn.data[`FSWD_PIN_DIR_BIT];
						st_nxt.pin1Sh.func = rptIn.data[`FSWD_PIN_FN_HI:0];
					end
				end
				PS_SKIP: begin
				end
				default: st_nxt.parse = PS_SKIP;
			endcase

			// ------------------------------------------------------------------
			// end of report: commit only a complete flash-write of a known kind
			// a report stopped before its last field is flagged, never half stored
			if (rptIn.last) begin
				commitChip = st_r.parse == PS_CHIP && st_r.idx >= `FSWD_IDX_PW_LAST;
				commitPin = st_r.parse == PS_PIN && st_r.idx >= `FSWD_IDX_PIN1;
				if (!commitChip && !commitPin && (st_nxt.cmdHit || st_r.parse != PS_SKIP)) begin
					evSet[`FSWD_ST_IGNORED] = 1'b1;
				end
				st_nxt.parse = PS_HEAD;
				st_nxt.idx = `FSWD_IDX_CMD;
				st_nxt.cmdHit = 1'b0;
			end
		end

		if (commitChip) begin
			st_nxt.chip = st_nxt.chipSh;
			st_nxt.usb.vendorId = st_nxt.vidSh;
			st_nxt.usb.productId = st_nxt.pidSh;
			st_nxt.usb.powerAttr = st_nxt.attrSh;
			st_nxt.usb.currentMa = {st_nxt.curSh, 1'b0};
			st_nxt.pwBank = !st_r.pwBank;
			evSet[`FSWD_ST_CHIP] = 1'b1;
		end
		if (commitPin) begin
			st_nxt.pin0 = st_nxt.pin0Sh;
			st_nxt.pin1 = st_nxt.pin1Sh;
			evSet[`FSWD_ST_PIN] = 1'b1;
		end

		// power-up drive of the pins: level on both pins, drive enable only where the pin is a general output
		st_nxt.pinOut = levelBits;
		st_nxt.pinOeN = ~drive;

		// ------------------------------------------------------------------
		// register writes, no wait states
		// byte lane zero gates every write: all writable fields live there
		if (write) begin
			case (address)
				`FSWD_REG_STATUS: if (byteenable[0]) evClr = writedata[3:0];
				`FSWD_REG_MASK: if (byteenable[0]) st_nxt.mask = writedata[3:0];
				`FSWD_REG_PW_INDEX: if (byteenable[0]) st_nxt.pwIndex = writedata[2:0];
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------------
		// register reads: phase 0 addresses memory, phase 1 loads data, phase 2 answers
		if (read) begin
			if (st_r.rdPhase == `FSWD_RD_LAST_PHASE) begin
				st_nxt.rdPhase = 2'h0;
			end else begin
				st_nxt.rdPhase = 2'(st_r.rdPhase + 2'h1);
			end
			if (st_r.rdPhase == 2'h1) begin
				st_nxt.rdata = rdMux;
			end
		end else begin
			st_nxt.rdPhase = 2'h0;
		end

		// sticky status: an event in the clearing cycle survives
		st_nxt.status = (st_r.status & ~evClr) | evSet;
		// irq from next values so it rises on the same edge as its status bit
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
	end

	// ======================================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= '0;
			st_r.parse <= PS_HEAD;
			st_r.chipSh <= `FSWD_RST_CHIP;
			st_r.chip <= `FSWD_RST_CHIP;
			st_r.usb <= {`FSWD_RST_PID, `FSWD_RST_VID, `FSWD_RST_ATTR, `FSWD_RST_CURRENT};
			// pins wake as general inputs: nothing is driven before a pin commit
			st_r.pin0Sh <= `FSWD_RST_PIN;
			st_r.pin1Sh <= `FSWD_RST_PIN;
			st_r.pin0 <= `FSWD_RST_PIN;
			st_r.pin1 <= `FSWD_RST_PIN;
			st_r.pinOeN <= 2'h3;
			st_r.mask <= `FSWD_RST_MASK;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ======================================================================
	// outputs
	assign chipCfg = st_r.chip;
	assign usbCfg = st_r.usb;
	assign pin0Cfg = st_r.pin0;
	assign pin1Cfg = st_r.pin1;
	assign pinOut = st_r.pinOut;
	assign pinOeN = st_r.pinOeN;
	assign irq = st_r.irq;
	assign readdata = st_r.rdata;
	// writes never wait; reads wait until the registered data stands
	assign waitrequest = read && st_r.rdPhase != `FSWD_RD_LAST_PHASE;

endmodule

// >>> hw/fswd_pkg.sv
// types of the flash settings write decoder
package fswd_pkg;

	typedef enum logic [1:0] {PS_HEAD, PS_CHIP, PS_PIN, PS_SKIP} fswd_parse_type;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} fswd_byte_type;

	typedef struct packed {
		logic negEdgeEn;
		logic posEdgeEn;
		logic [1:0] adcRefLevel;
		logic adcRefInternal;
	} fswd_chip_type;

	typedef struct packed {
		logic [15:0] productId;
		logic [15:0] vendorId;
		logic [7:0] powerAttr;
		logic [8:0] currentMa;
	} fswd_usb_type;

	typedef struct packed {
		logic level;
		logic dirInput;
		logic [2:0] func;
	} fswd_pin_type;

endpackage

// >>> hw/fswd_pw_mem.sv
// password store: two banks, registered read port
`timescale 1ns/10ps
module fswd_pw_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gDepthCheck
		$error("fswd_pw_mem: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end

endmodule

// >>> hw/fswd_regs.svh
// constants of the flash settings write decoder: codes, byte indices, fields, offsets, resets
`ifndef FSWD_REGS_SVH
`define FSWD_REGS_SVH

// ==========================================================================
// report codes
`define FSWD_CMD_FLASH_WRITE 8'hb1
`define FSWD_SUB_CHIP 8'h00
`define FSWD_SUB_PIN 8'h01

// ==========================================================================
// byte indices within a report
`define FSWD_IDX_CMD 6'h00
`define FSWD_IDX_SUB 6'h01
`define FSWD_IDX_PIN0 6'h02
`define FSWD_IDX_PIN1 6'h03
`define FSWD_IDX_EDGE 6'h05
`define FSWD_IDX_VID_LO 6'h06
`define FSWD_IDX_VID_HI 6'h07
`define FSWD_IDX_PID_LO 6'h08
`define FSWD_IDX_PID_HI 6'h09
`define FSWD_IDX_ATTR 6'h0a
`define FSWD_IDX_CURRENT 6'h0b
`define FSWD_IDX_PW_FIRST 6'h0c
`define FSWD_IDX_PW_LAST 6'h13

// ==========================================================================
// field positions
`define FSWD_NEG_BIT 6
`define FSWD_POS_BIT 5
`define FSWD_REF_HI 4
`define FSWD_REF_LO 3
`define FSWD_SRC_BIT 2
`define FSWD_PIN_LVL_BIT 4
`define FSWD_PIN_DIR_BIT 3
`define FSWD_PIN_FN_HI 2
`define FSWD_PIN_FN_GENERAL 3'h0

// status and mask bits
`define FSWD_ST_CHIP 0
`define FSWD_ST_PIN 1
`define FSWD_ST_IGNORED 2
`define FSWD_ST_EDGE 3

// ==========================================================================
// register byte offsets
`define FSWD_REG_STATUS 5'h00
`define FSWD_REG_MASK 5'h04
`define FSWD_REG_CHIP 5'h08
`define FSWD_REG_USB_ID 5'h0c
`define FSWD_REG_USB_POWER 5'h10
`define FSWD_REG_PIN 5'h14
`define FSWD_REG_PW_INDEX 5'h18
`define FSWD_REG_PW_DATA 5'h1c

// ==========================================================================
// reset values
`define FSWD_RST_CHIP 5'h00
`define FSWD_RST_VID 16'h0000
`define FSWD_RST_PID 16'h0000
`define FSWD_RST_ATTR 8'h00
`define FSWD_RST_CURRENT 9'h000
`define FSWD_RST_PIN 5'h08
`define FSWD_RST_MASK 4'h0

// read wait states: two cycles so the password memory output is registered in time
`define FSWD_RD_LAST_PHASE 2'h2

`endif
